// ==== rtl/trr_map.svh ====
`ifndef TRR_MAP_SVH
`define TRR_MAP_SVH

// ---------------------------------------------------------------
// Register bus word offsets
// ---------------------------------------------------------------
`define TRR_REG_STATUS 2'h0
`define TRR_REG_PARITY_LOG 2'h1
`define TRR_REG_FLAGS 2'h2

// ---------------------------------------------------------------
// Power-up training patterns, locations zero to three
// ---------------------------------------------------------------
`define TRR_PAT0 8'h55
`define TRR_PAT1 8'h33
`define TRR_PAT2 8'h0F
`define TRR_PAT3 8'h00

// ---------------------------------------------------------------
// Mode word indices and field positions
// ---------------------------------------------------------------
`define TRR_MW_BURST 3'h0
`define TRR_MW_DRIVE 3'h1
`define TRR_MW_WLAT 3'h2
`define TRR_MW_TRAIN 3'h3
`define TRR_MW_PREAMBLE 3'h4
`define TRR_MW_PDBI 3'h5
`define TRR_MW_REFT 3'h6
`define TRR_TC_EN 2
`define TRR_TC_TEMP 5
`define TRR_TC_PAGE_LSB 0
`define TRR_TC_FMT_LSB 11
`define TRR_PRE_READ_BIT 11
`define TRR_FMT_SERIAL 2'h0
`define TRR_FMT_PARALLEL 2'h1
`define TRR_FMT_STAGGER 2'h2
`define TRR_BURST_CHOP 2'h2

// ---------------------------------------------------------------
// Latency and timing
// ---------------------------------------------------------------
`define TRR_CAS_BASE 7'h09
`define TRR_PLAT_BASE 7'h03
`define TRR_PIPE_DEPTH 64
`define TRR_CLK_NS 4
`define TRR_TEMP_AGE_MS 32

`endif

// ==== rtl/trr_pkg.sv ====
package trr_pkg;
    `include "trr_map.svh"

    // Command kinds from the controller side
    typedef enum logic [1:0] {
        TRR_CMD_NONE = 2'h0,
        TRR_CMD_MODE_WR = 2'h1,
        TRR_CMD_READ = 2'h2,
        TRR_CMD_WRITE = 2'h3
    } trr_cmd_t;

    // Output sequencer, Gray along idle-pre-data-tri
    typedef enum logic [1:0] {
        TRR_IDLE = 2'b00,
        TRR_PRE = 2'b01,
        TRR_DATA = 2'b11,
        TRR_TRI = 2'b10
    } trr_burst_t;

    // Pending read in the latency line
    typedef struct packed {
        logic v;
        logic chop;
        logic hi;
        logic [1:0] loc;
    } trr_entry_t;

    typedef struct packed {
        logic [7:0][13:0] mw;
        logic [3:0][7:0] pg0;
        trr_entry_t [`TRR_PIPE_DEPTH-1:0] pipe;
        trr_burst_t bst;
        logic [1:0] cnt;
        logic hi;
        logic chop;
        logic [15:0][7:0] lanes;
        logic [15:0] dq_rise;
        logic [15:0] dq_fall;
        logic dq_oe_n;
        logic dqs_oe_n;
        logic dqs_run;
        logic [1:0] temp_s1;
        logic [1:0] temp_s2;
        logic [1:0] temp;
        logic [31:0] temp_cnt;
        logic [23:0] parity_log;
        logic parity_err;
        logic crc_err;
        logic soft_rep;
        logic hard_rep;
        logic [3:0] act_code;
        logic waitreq;
        logic [31:0] rdata;
    } trr_state_t;
endpackage : trr_pkg

// ==== rtl/trr_training_readout.sv ====
// What this block does
// - After reset, locations 0-3 of page zero hold 55, 33, 0F, 00.
// - Page zero keeps written values until reset; other pages never written.
// - Parity page location 3: latency bits 2:0, parity bit 6, CRC bit 7.
// - Temperature status refreshed while enabled, at most 32 ms old.
// - Temperature code: 00 below 1X, 01 1X, 10 2X, 11 reserved.
// - Page two reads back mode word fields and repair flags.
// - Page three reads zero except location 3 bits 3:0, activation code.
// - Reads use fixed eight-beat or fixed chopped-four; no on-the-fly.
// - Read data is never inverted while the mode is active.
// - Chopped reads start at beat 0 or 4; last four beats tri-stated.
// - Format 00 serial, 01 parallel, 10 staggered; page field selects page.
// - Bank bits select the location; other address bits ignored.
// - Data starts additive plus CAS plus parity latency after the read command.
// - Mode, temperature and parity pages are read in the selected format, like page zero.
// - Strobes driven with training data, honouring preamble setting.
// - Serial: all lanes carry the same byte, MSB first.
// - Parallel: byte bits spread over lanes, repeated every beat.
// - Staggered: lane n carries location (k+n) mod 4.
// - Page zero write takes address bits 7:0 into the selected location.
// - Upper nibble lanes repeat the lower nibble staggered pattern.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "trr_map.svh"
module trr_training_readout
    import trr_pkg::*;
#(
    parameter int TEMP_CYC = `TRR_TEMP_AGE_MS * 1000000 / `TRR_CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_kind,
    input wire logic cmd_bg,
    input wire logic [1:0] cmd_ba,
    input wire logic [17:0] cmd_addr,
    input wire logic [1:0] temp_sense,
    output logic [15:0] dq_rise,
    output logic [15:0] dq_fall,
    output logic dq_oe_n,
    output logic dqs_run,
    output logic dqs_oe_n,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // -----------------------------------------------------------
    // State and mode decode
    // -----------------------------------------------------------
    trr_state_t st;
    trr_state_t next_st;
    logic mode_on;
    logic [1:0] page;
    logic [1:0] fmt;
    logic chop_mode;
    logic [6:0] cas_lat;
    logic [6:0] add_lat;
    logic [6:0] par_lat;
    logic [6:0] read_lat;
    logic [5:0] slot;
    logic read_ok;
    logic write_ok;
    logic starting;
    logic pre_pend;
    logic [7:0] first_byte;
    logic [15:0][7:0] lane_byte;
    logic [31:0] rd_word;

    assign mode_on = st.mw[`TRR_MW_TRAIN][`TRR_TC_EN];
    assign page = st.mw[`TRR_MW_TRAIN][`TRR_TC_PAGE_LSB +: 2];
    assign fmt = st.mw[`TRR_MW_TRAIN][`TRR_TC_FMT_LSB +: 2];
    // Only the fixed chop code chops; on-the-fly runs full length
    assign chop_mode = st.mw[`TRR_MW_BURST][1:0] == `TRR_BURST_CHOP;

    // Latency from the stored mode words
    assign cas_lat = 7'({st.mw[`TRR_MW_BURST][6:4],
        st.mw[`TRR_MW_BURST][2]}) + `TRR_CAS_BASE;
    always_comb begin
        case (st.mw[`TRR_MW_DRIVE][4:3])
            2'h1: add_lat = cas_lat - 7'h01;
            2'h2: add_lat = cas_lat - 7'h02;
            default: add_lat = 7'h00;
        endcase
    end
    assign par_lat = (st.mw[`TRR_MW_PDBI][2:0] == 3'h0) ? 7'h00 :
        7'(st.mw[`TRR_MW_PDBI][2:0]) + `TRR_PLAT_BASE;
    assign read_lat = add_lat + cas_lat + par_lat;
    assign slot = 6'(read_lat - 7'h01);

    // Command qualification; bank group and high bits dropped
    assign read_ok = cmd_valid && cmd_kind == TRR_CMD_READ && mode_on;
    assign write_ok = cmd_valid && cmd_kind == TRR_CMD_WRITE &&
        mode_on && page == 2'h0;

    // Burst start when the sequencer can take a new burst
    assign starting = st.pipe[0].v && (st.bst == TRR_IDLE ||
        st.bst == TRR_PRE || st.cnt == 2'h3);
    // Preamble: one or two cycles ahead of the first data
    assign pre_pend = st.pipe[1].v ||
        (st.mw[`TRR_MW_PREAMBLE][`TRR_PRE_READ_BIT] && st.pipe[2].v);

    // -----------------------------------------------------------
    // Location contents per page
    // -----------------------------------------------------------
    function automatic logic [7:0] loc_byte(input logic [1:0] l);
        logic [13:0] w2;
        logic [7:0] b;
        w2 = st.mw[`TRR_MW_WLAT];
        b = 8'h00;
        case (page)
            2'h0: b = st.pg0[l];
            2'h1: begin
                case (l)
                    2'h0: b = st.parity_log[7:0];
                    2'h1: b = st.parity_log[15:8];
                    2'h2: b = st.parity_log[23:16];
                    default: b = {st.crc_err, st.parity_err, 3'h0,
                        st.mw[`TRR_MW_PDBI][2:0]};
                endcase
            end
            2'h2: begin
                case (l)
                    2'h0: b = {st.hard_rep, st.soft_rep, w2[11],
                        st.temp, w2[12], w2[10], w2[9]};
                    2'h1: b = {st.mw[`TRR_MW_REFT][6:0],
                        st.mw[`TRR_MW_TRAIN][3]};
                    2'h2: b = {st.mw[`TRR_MW_BURST][6:4],
                        st.mw[`TRR_MW_BURST][2], 1'b0, w2[5:3]};
                    default: b = {st.mw[`TRR_MW_DRIVE][10:9],
                        st.mw[`TRR_MW_DRIVE][6],
                        st.mw[`TRR_MW_PDBI][8:6],
                        st.mw[`TRR_MW_DRIVE][2:1]};
                endcase
            end
            default: begin
                // Restricted page reads zero but the code
                if (l == 2'h3) begin
                    b = {4'h0, st.act_code};
                end
            end
        endcase
        return b;
    endfunction : loc_byte

    // Lookup reads live state, so a process keeps it in step with it
    always_comb begin
        first_byte = loc_byte(st.pipe[0].loc);
    end

    // -----------------------------------------------------------
    // Lane shaping per read format
    // -----------------------------------------------------------
    for (genvar n = 0; n < 16; n++) begin : g_lane
        logic [1:0] sloc;
        logic [7:0] stag;
        // Staggered location wraps every nibble
        assign sloc = st.pipe[0].loc + 2'(n % 4);
        // Process, so page or pattern changes are seen at once
        always_comb begin
            stag = loc_byte(sloc);
        end
        assign lane_byte[n] = (fmt == `TRR_FMT_PARALLEL) ?
            {8{first_byte[7 - (n % 8)]}} :
            (fmt == `TRR_FMT_STAGGER) ? stag :
            first_byte;
    end

    // -----------------------------------------------------------
    // Register readback
    // -----------------------------------------------------------
    always_comb begin
        case (avs_address)
            `TRR_REG_STATUS: rd_word = {24'h0, st.temp,
                st.bst != TRR_IDLE, fmt, page, mode_on};
            `TRR_REG_PARITY_LOG: rd_word = {8'h0, st.parity_log};
            `TRR_REG_FLAGS: rd_word = {24'h0, st.act_code,
                st.hard_rep, st.soft_rep, st.crc_err, st.parity_err};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // -----------------------------------------------------------
    // Next state
    // -----------------------------------------------------------
    always_comb begin
        logic [2:0] b0;
        next_st = st;
        b0 = 3'h0;

        // Bus slave: one wait cycle, then a one-cycle answer
        next_st.waitreq = 1'b1;
        if ((avs_read || avs_write) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata = rd_word;
        end
        if (avs_write && !st.waitreq) begin
            case (avs_address)
                `TRR_REG_PARITY_LOG: begin
                    next_st.parity_log = avs_writedata[23:0];
                end
                `TRR_REG_FLAGS: begin
                    next_st.parity_err = avs_writedata[0];
                    next_st.crc_err = avs_writedata[1];
                    next_st.soft_rep = avs_writedata[2];
                    next_st.hard_rep = avs_writedata[3];
                    next_st.act_code = avs_writedata[7:4];
                end
                default: begin
                end
            endcase
        end

        // Temperature status, sampled through two flops
        next_st.temp_s1 = temp_sense;
        next_st.temp_s2 = st.temp_s1;
        if (st.mw[`TRR_MW_TRAIN][`TRR_TC_TEMP]) begin
            // Refresh at least every period; code kept as-is
            if (st.temp_cnt == 32'h0) begin
                next_st.temp = st.temp_s2;
                next_st.temp_cnt = 32'(TEMP_CYC - 1);
            end else begin
                next_st.temp_cnt = st.temp_cnt - 32'h1;
            end
        end

        // Latency line advances one slot per clock
        next_st.pipe = {5'h00, st.pipe[`TRR_PIPE_DEPTH-1:1]};

        // Commands
        if (cmd_valid && cmd_kind == TRR_CMD_MODE_WR) begin
            next_st.mw[{cmd_bg, cmd_ba}] = cmd_addr[13:0];
        end
        if (read_ok) begin
            // Only bank bits, chop code and column bit 2 matter
            next_st.pipe[slot] = {1'b1, chop_mode,
                chop_mode && cmd_addr[2], cmd_ba};
        end
        if (write_ok) begin
            next_st.pg0[cmd_ba] = cmd_addr[7:0];
        end

        // Output sequencer
        if (starting) begin
            next_st.bst = TRR_DATA;
            next_st.cnt = 2'h0;
            next_st.chop = st.pipe[0].chop;
            next_st.hi = st.pipe[0].hi;
            next_st.lanes = lane_byte;
        end else begin
            case (st.bst)
                TRR_IDLE, TRR_PRE: begin
                    next_st.bst = pre_pend ? TRR_PRE : TRR_IDLE;
                end
                TRR_DATA, TRR_TRI: begin
                    if (st.cnt == 2'h3) begin
                        next_st.bst = pre_pend ? TRR_PRE : TRR_IDLE;
                    end else begin
                        next_st.cnt = st.cnt + 2'h1;
                        // Chopped burst floats its second half
                        if (st.chop && st.cnt == 2'h1) begin
                            next_st.bst = TRR_TRI;
                        end
                    end
                end
                default: begin
                    next_st.bst = TRR_IDLE;
                end
            endcase
        end

        // Pins: two beats per clock, MSB of the byte first
        b0 = {next_st.cnt[1] | next_st.hi, next_st.cnt[0], 1'b0};
        for (int n = 0; n < 16; n++) begin
            // Plain data, never inverted in this mode
            next_st.dq_rise[n] = next_st.lanes[n][~b0];
            next_st.dq_fall[n] = next_st.lanes[n][~(b0 | 3'h1)];
        end
        next_st.dq_oe_n = next_st.bst != TRR_DATA;
        next_st.dqs_run = next_st.bst == TRR_DATA;
        next_st.dqs_oe_n = !(next_st.bst == TRR_DATA ||
            next_st.bst == TRR_PRE);
    end

    // -----------------------------------------------------------
    // State register
    // -----------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.pg0 <= {`TRR_PAT3, `TRR_PAT2, `TRR_PAT1, `TRR_PAT0};
            st.waitreq <= 1'b1;
            st.dq_oe_n <= 1'b1;
            st.dqs_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign dq_rise = st.dq_rise;
    assign dq_fall = st.dq_fall;
    assign dq_oe_n = st.dq_oe_n;
    assign dqs_run = st.dqs_run;
    assign dqs_oe_n = st.dqs_oe_n;
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_page0_defaults: assert property (
        disable iff (1'b0) $past(rst) && !rst |->
        st.pg0 == {`TRR_PAT3, `TRR_PAT2, `TRR_PAT1, `TRR_PAT0})
        else $error("page zero not at power-up patterns");
    a_page0_hold: assert property (!write_ok |=> $stable(st.pg0))
        else $error("page zero changed without a write");
    a_page0_write: assert property (write_ok |=>
        st.pg0[$past(cmd_ba)] == $past(cmd_addr[7:0]))
        else $error("page zero write lost");
    a_parity_loc3: assert property (starting && page == 2'h1 &&
        st.pipe[0].loc == 2'h3 && fmt == `TRR_FMT_SERIAL |=>
        st.lanes[0] == {$past(st.crc_err), $past(st.parity_err),
        3'h0, $past(st.mw[`TRR_MW_PDBI][2:0])})
        else $error("parity location three wrong");
    a_temp_frozen: assert property (
        !st.mw[`TRR_MW_TRAIN][`TRR_TC_TEMP] |=> $stable(st.temp))
        else $error("temperature changed while disabled");
    a_temp_age: assert property (
        st.temp_cnt < 32'(TEMP_CYC))
        else $error("temperature refresh period exceeded");
    a_read_slot: assert property (read_ok |=>
        st.pipe[$past(slot)].v && st.pipe[$past(slot)].loc == $past(cmd_ba))
        else $error("read not queued at its latency");
    a_full_burst: assert property (starting && !st.pipe[0].chop |=>
        !dq_oe_n [*4])
        else $error("eight-beat burst cut short");
    a_chop_burst: assert property (starting && st.pipe[0].chop &&
        !st.pipe[1].v && !st.pipe[2].v && !st.pipe[3].v |=>
        !dq_oe_n [*2] ##1 dq_oe_n [*2])
        else $error("chopped burst not floated");
    a_serial_lanes: assert property (
        starting && fmt == `TRR_FMT_SERIAL |=>
        st.lanes == {16{st.lanes[0]}})
        else $error("serial lanes differ");
    a_stagger_nib: assert property (
        starting && fmt == `TRR_FMT_STAGGER |=>
        st.lanes[7:4] == st.lanes[3:0] &&
        st.lanes[15:8] == st.lanes[7:0] &&
        (st.lanes[1] != st.lanes[0] || $past(st.pipe[0].loc) != 2'h0 ||
        $past(page) != 2'h0 || $past(st.pg0[1]) == $past(st.pg0[0])))
        else $error("staggered lanes misplaced");

    c_serial_read: cover property (starting && fmt == `TRR_FMT_SERIAL);
    c_stagger_read: cover property (starting && fmt == `TRR_FMT_STAGGER);
    c_chop_read: cover property (starting && st.pipe[0].chop);
    c_back_to_back: cover property (st.bst == TRR_DATA &&
        st.cnt == 2'h3 && st.pipe[0].v);

endmodule : trr_training_readout

// ==== tb/trr_ctrl_model.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Controller stand-in on the command side
// ---------------------------------------------------------------
module trr_ctrl_model
    import trr_pkg::*;
(
    input wire logic clk,
    output logic cmd_valid,
    output logic [1:0] cmd_kind,
    output logic cmd_bg,
    output logic [1:0] cmd_ba,
    output logic [17:0] cmd_addr
);
    // Quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_kind = 2'h0;
        cmd_bg = 1'b0;
        cmd_ba = 2'h0;
        cmd_addr = 18'h00000;
    end

    // One-cycle command; idle lines show inverted junk, not stale values
    task automatic issue(input logic [1:0] k, input logic bg,
        input logic [1:0] ba, input logic [17:0] a);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_bg <= bg;
        cmd_ba <= ba;
        cmd_addr <= a;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_kind <= ~k;
        cmd_bg <= ~bg;
        cmd_ba <= ~ba;
        cmd_addr <= ~a;
    endtask : issue

    // Mode write, then the update delay before any further command
    task automatic mode_wr(input logic [2:0] i, input logic [13:0] v);
        issue(2'h1, i[2], i[1:0], {4'h0, v});
        repeat (24) @(posedge clk);
    endtask : mode_wr

    // Read: long spacing always; column low bits zero, autoclose set
    task automatic rd(input logic [1:0] loc, input logic a2);
        repeat (6) @(posedge clk);
        issue(2'h2, 1'b1, loc, {7'h00, 1'b1, 7'h00, a2, 2'b00});
    endtask : rd

    // Page zero write carries its byte on the low address bits
    task automatic wr(input logic [1:0] loc, input logic [7:0] d);
        issue(2'h3, 1'b1, loc, {10'h000, d});
        repeat (8) @(posedge clk);
    endtask : wr

    // Recovery wait, then clear the enable bit
    task automatic leave;
        repeat (12) @(posedge clk);
        mode_wr(3'h3, 14'h0000);
    endtask : leave
endmodule : trr_ctrl_model

// ==== tb/trr_training_readout_test.sv ====
`timescale 1ns/1ns
module trr_training_readout_test
    import trr_pkg::*;
;
    logic clk, rst, cmd_valid, cmd_bg, dq_oe_n, dqs_run, dqs_oe_n, pre2;
    logic [1:0] cmd_kind, cmd_ba, temp_sense, avs_address;
    logic [17:0] cmd_addr;
    logic [15:0] dq_rise, dq_fall;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    int mismatches = 0, n_checks = 0;
    trr_ctrl_model trr_ctrl_model_inst (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba),
        .cmd_addr(cmd_addr));
    trr_training_readout #(.TEMP_CYC(16)) trr_training_readout_inst (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
        .temp_sense(temp_sense), .dq_rise(dq_rise), .dq_fall(dq_fall),
        .dq_oe_n(dq_oe_n), .dqs_run(dqs_run), .dqs_oe_n(dqs_oe_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // Shared checks and bus cycles
    // ---------------------------------------------------------------
    task automatic chk_bus(input string s, input logic [15:0] e,
        input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk_bus
    task automatic chk_word(input string s, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk_word
    // Avalon access; held until waitrequest is seen low at an edge
    task automatic av(input logic [1:0] a, input logic w,
        input logic [31:0] d);
        int t = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk_word("waitrequest", 0, avs_waitrequest);
    endtask : av
    function automatic logic [13:0] mw3(input logic [1:0] f,
        input logic [1:0] p, input logic t);
        mw3 = {1'b0, f, 5'h00, t, 2'h0, 1'b1, p};
    endfunction : mw3
    function automatic logic [15:0][7:0] ser(input logic [7:0] v);
        ser = {16{v}};
    endfunction : ser
    // Read a location, then time and judge the whole burst
    task automatic rd_chk(input logic [1:0] loc, input logic a2,
        input logic [15:0][7:0] l, input int rl, input logic chop);
        int k = 0, b;
        logic p1 = 1'b1, p2, s = 1'b1;
        logic [15:0] er, ef;
        trr_ctrl_model_inst.rd(loc, a2);
        do begin
            @(posedge clk);
            #1;
            k++;
            p2 = p1;
            p1 = s;
            s = dqs_oe_n;
        end while (dq_oe_n !== 1'b0 && k < 200);
        chk_word("latency", rl, k);
        chk_word("strobe", {~pre2, 3'b001}, {p2, p1, s, dqs_run});
        for (int c = 0; c < 4; c++) begin
            if (c > 0) begin
                @(posedge clk);
                #1;
            end
            b = (chop && a2) ? 4 + 2 * c : 2 * c;
            if (chop && c > 1) begin
                chk_word("tristate", 1, dq_oe_n);
            end else begin
                for (int n = 0; n < 16; n++) begin
                    er[n] = l[n][7 - b];
                    ef[n] = l[n][6 - b];
                end
                chk_bus("rise beat", er, dq_rise);
                chk_bus("fall beat", ef, dq_fall);
            end
        end
    endtask : rd_chk
    // Count driven cycles after a read that must be ignored
    task automatic idle_chk;
        int lo = 0;
        trr_ctrl_model_inst.rd(2'h0, 1'b0);
        repeat (40) begin
            @(posedge clk);
            #1;
            lo += (dq_oe_n !== 1'b1);
        end
        chk_word("idle dq", 0, lo);
    endtask : idle_chk
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        av(2'h0, 1'b0, 0);
        chk_word("status", 0, q);
        av(2'h3, 1'b1, 32'hFFFFFFFF);
        av(2'h3, 1'b0, 0);
        chk_word("unmapped", 0, q);
        av(2'h1, 1'b1, 32'h00C3B2A1);
        av(2'h1, 1'b0, 0);
        chk_word("parity log", 32'h00C3B2A1, q);
        idle_chk();
        $display("test regs done");
    endtask : t_regs
    task automatic t_serial;
        logic [3:0][7:0] pat;
        pat = {8'h00, 8'h0F, 8'h33, 8'h55};
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h0, 1'b0));
        av(2'h0, 1'b0, 0);
        chk_word("status on", 1, q);
        for (int i = 0; i < 4; i++) begin
            rd_chk(i[1:0], 1'b0, ser(pat[i]), 9, 1'b0);
        end
        trr_ctrl_model_inst.wr(2'h1, 8'hA5);
        rd_chk(2'h1, 1'b0, ser(8'hA5), 9, 1'b0);
        $display("test serial done");
    endtask : t_serial
    task automatic t_formats;
        logic [3:0][7:0] pg;
        logic [15:0][7:0] l;
        pg = {8'h00, 8'h0F, 8'hA5, 8'h55};
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h2, 2'h0, 1'b0));
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < 16; n++) begin
                l[n] = pg[(k + n) % 4];
            end
            rd_chk(k[1:0], 1'b0, l, 9, 1'b0);
        end
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h1, 2'h0, 1'b0));
        for (int n = 0; n < 16; n++) begin
            l[n] = {8{pg[0][7 - (n % 8)]}};
        end
        rd_chk(2'h0, 1'b0, l, 9, 1'b0);
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h3, 2'h0, 1'b0));
        rd_chk(2'h2, 1'b0, ser(8'h0F), 9, 1'b0);
        $display("test formats done");
    endtask : t_formats
    task automatic t_chop;
        trr_ctrl_model_inst.mode_wr(3'h0, 14'h0012);
        trr_ctrl_model_inst.mode_wr(3'h4, 14'h0800);
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h0, 1'b0));
        pre2 = 1'b1;
        rd_chk(2'h0, 1'b1, ser(8'h55), 11, 1'b1);
        rd_chk(2'h0, 1'b0, ser(8'h55), 11, 1'b1);
        trr_ctrl_model_inst.mode_wr(3'h1, 14'h0008);
        rd_chk(2'h2, 1'b0, ser(8'h0F), 21, 1'b1);
        trr_ctrl_model_inst.mode_wr(3'h0, 14'h0000);
        trr_ctrl_model_inst.mode_wr(3'h1, 14'h0000);
        trr_ctrl_model_inst.mode_wr(3'h4, 14'h0000);
        pre2 = 1'b0;
        $display("test chop done");
    endtask : t_chop
    task automatic t_pages;
        av(2'h2, 1'b1, 32'h00000003);
        trr_ctrl_model_inst.mode_wr(3'h5, 14'h1001);
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h1, 1'b0));
        rd_chk(2'h0, 1'b0, ser(8'hA1), 13, 1'b0);
        rd_chk(2'h3, 1'b0, ser(8'hC1), 13, 1'b0);
        trr_ctrl_model_inst.wr(2'h0, 8'h11);
        trr_ctrl_model_inst.mode_wr(3'h5, 14'h0000);
        av(2'h2, 1'b1, 32'h00000094);
        trr_ctrl_model_inst.mode_wr(3'h2, 14'h1000);
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h2, 1'b1));
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            temp_sense <= c[1:0];
            repeat (40) @(posedge clk);
            rd_chk(2'h0, 1'b0, ser(8'h44 | 8'(c << 3)), 9, 1'b0);
        end
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h2, 1'b0));
        temp_sense <= 2'h0;
        repeat (40) @(posedge clk);
        rd_chk(2'h0, 1'b0, ser(8'h5C), 9, 1'b0);
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h3, 1'b0));
        rd_chk(2'h3, 1'b0, ser(8'h09), 9, 1'b0);
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h0, 1'b0));
        rd_chk(2'h0, 1'b0, ser(8'h55), 9, 1'b0);
        trr_ctrl_model_inst.leave();
        idle_chk();
        $display("test pages done");
    endtask : t_pages
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        trr_ctrl_model_inst.mode_wr(3'h3, mw3(2'h0, 2'h0, 1'b0));
        rd_chk(2'h1, 1'b0, ser(8'h33), 9, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // Watchdog: 25000 cycles, far beyond the under 1500 cycles the run needs
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        temp_sense = 2'h0;
        avs_address = 2'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        pre2 = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_serial();
        t_formats();
        t_chop();
        t_pages();
        t_reset();
        final_report();
    end
endmodule : trr_training_readout_test
